// file: pkg/sysopt_pkg.sv
// Constants for the system options, wakeup timer and low-voltage register bank
// Operation
// R1 - Option bit 7 picks watchdog clock, once
// R2 - Write-once bits keep first write after reset
// R3 - Option bit 0 routes comparator to capture
// R4 - Id high bits 7:4 unspecified, unwritable
// R5 - Id registers read-only, fixed part number
// R6 - Wakeup flag set on timeout, sticky
// R7 - Writing ack 1 clears wakeup flag
// R8 - Wakeup enable raises request while flag set
// R9 - Period code 000 off, 8 ms-1.024 s
// R10 - External clock periods 256 to 32768
// R11 - First timeout may come one tick early
// R12 - Low-voltage flag set only when detection enabled
// R13 - Writing ack 1 clears low-voltage flag
// R14 - Low-voltage irq enable requests interrupt on flag
// R15 - Reset enable, once, forces reset on flag
// R16 - Stop enable keeps detector running in stop
// R17 - Detect enable, once, gates flag/reset/stop
// R18 - Bandgap buffer enable drives reference buffer
// R19 - Software writes zero to reserved bit 1
// R20 - Trip select bit picks high or low point
// R21 - Detector input synchronised before use
package sysopt_pkg;
    localparam logic [2:0] ADDR_OPT2    = 3'h0;
    localparam logic [2:0] ADDR_ID_HIGH = 3'h1;
    localparam logic [2:0] ADDR_ID_LOW  = 3'h2;
    localparam logic [2:0] ADDR_WAKEUP  = 3'h3;
    localparam logic [2:0] ADDR_PWR1    = 3'h4;
    localparam logic [2:0] ADDR_PWR3    = 3'h5;

    localparam int OPT_WDOG_CLK_BIT   = 7;
    localparam int OPT_CMP_ROUTE_BIT  = 0;
    localparam int WK_FLAG_BIT        = 7;
    localparam int WK_ACK_BIT         = 6;
    localparam int WK_IRQ_EN_BIT      = 4;
    localparam int PM_FLAG_BIT        = 7;
    localparam int PM_ACK_BIT         = 6;
    localparam int PM_IRQ_EN_BIT      = 5;
    localparam int PM_RST_EN_BIT      = 4;
    localparam int PM_STOP_EN_BIT     = 3;
    localparam int PM_DET_EN_BIT      = 2;
    localparam int PM_BGAP_BIT        = 0;
    localparam int PM3_TRIP_BIT       = 5;

    // Reset values
    localparam logic [7:0] OPT2_RESET = 8'h00;
    localparam logic [7:0] WK_RESET   = 8'h00;
    localparam logic [7:0] PM1_RESET  = 8'h1c;

    // Arbitrary identification value, not a real part number
    localparam logic [11:0] PART_ID = 12'h5a3;

    localparam int CLK_HZ      = 50000000;
    localparam int TICK_HZ     = 1000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
endpackage : sysopt_pkg

// file: verilog/sysopt_regs.sv
// System options, part id, periodic wakeup timer and low-voltage detect registers
`timescale 1ns/100ps
module sysopt_regs
    import sysopt_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic [2:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       LV_DETECT_ASYNC,
    input  wire logic       EXT_CLK_TICK,
    input  wire logic       WAKEUP_SRC_EXT,
    input  wire logic       STOP_MODE,
    input  wire logic       COMPARATOR_OUT,
    output logic            CAPTURE_CH0_IN,
    output logic            WATCHDOG_CLOCK_SELECT,
    output logic            WAKEUP_IRQ,
    output logic            LOW_VOLTAGE_IRQ,
    output logic            LOW_VOLTAGE_RESET,
    output logic            DETECTOR_ENABLE,
    output logic            LOW_VOLTAGE_TRIP_SELECT,
    output logic            BANDGAP_BUFFER_ENABLE
);
    typedef struct packed {
        logic [7:0]  rdata;
        logic        wdog_clk;
        logic        cmp_route;
        logic        opt_written;
        logic        wk_flag;
        logic        wk_irq_en;
        logic [2:0]  wk_period;
        logic [15:0] tick_div;
        logic [15:0] wk_count;
        logic        lv_flag;
        logic        lv_irq_en;
        logic        lv_rst_en;
        logic        lv_stop_en;
        logic        lv_det_en;
        logic        pm_once_written;
        logic        bgap;
        logic        trip_sel;
        logic        lv_meta;
        logic        lv_sync;
        logic        capture;
        logic        wake_irq;
        logic        lv_irq;
        logic        lv_reset;
        logic        det_on;
    } state_t;

    localparam state_t STATE_RESET = '{
        rdata: 8'h00, wdog_clk: OPT2_RESET[OPT_WDOG_CLK_BIT],
        cmp_route: OPT2_RESET[OPT_CMP_ROUTE_BIT], opt_written: 1'b0,
        wk_flag: 1'b0, wk_irq_en: 1'b0, wk_period: 3'h0, tick_div: 16'h0000,
        wk_count: 16'h0000, lv_flag: 1'b0, lv_irq_en: 1'b0,
        lv_rst_en: PM1_RESET[PM_RST_EN_BIT], lv_stop_en: PM1_RESET[PM_STOP_EN_BIT],
        lv_det_en: PM1_RESET[PM_DET_EN_BIT], pm_once_written: 1'b0, bgap: 1'b0,
        trip_sel: 1'b0, lv_meta: 1'b0, lv_sync: 1'b0, capture: 1'b0,
        wake_irq: 1'b0, lv_irq: 1'b0, lv_reset: 1'b0, det_on: 1'b0
    };

    state_t st;
    state_t next_st;

    // Last count index for a period code; the tick source sets the scale
    function automatic logic [15:0] period_last(input logic [2:0] code, input logic ext);
        logic [15:0] n;
        n = 16'h0000;
        if (ext) begin
            n = (code == 3'h1) ? 16'd255 : 16'((32'd1 << (32'(code) + 32'd8)) - 32'd1); // R10
        end else begin
            case (code) // R9
                3'h1:    n = 16'd7;
                3'h2:    n = 16'd31;
                3'h3:    n = 16'd63;
                3'h4:    n = 16'd127;
                3'h5:    n = 16'd255;
                3'h6:    n = 16'd511;
                3'h7:    n = 16'd1023;
                default: n = 16'd0;
            endcase
        end
        return n;
    endfunction : period_last

    logic        tick;
    logic        wk_timeout;
    logic        wr_opt;
    logic        wr_wk;
    logic        wr_pm1;

    always_comb begin
        next_st = st;
        wr_opt  = WR && (ADDR == ADDR_OPT2);
        wr_wk   = WR && (ADDR == ADDR_WAKEUP);
        wr_pm1  = WR && (ADDR == ADDR_PWR1);

        // Synchroniser: first stage feeds only the second
        next_st.lv_meta = LV_DETECT_ASYNC; // R21
        next_st.lv_sync = st.lv_meta; // R21

        // Option register: both bits taken once, first write only
        if (wr_opt && !st.opt_written) begin // R2
            next_st.wdog_clk    = WDATA[OPT_WDOG_CLK_BIT]; // R1
            next_st.cmp_route   = WDATA[OPT_CMP_ROUTE_BIT];
            next_st.opt_written = 1'b1;
        end

        // 1 kHz tick divider runs free, so the first period may be short
        tick = 1'b0;
        if (st.tick_div == TICK_LAST) begin
            next_st.tick_div = 16'h0000;
            tick             = 1'b1;
        end else begin
            next_st.tick_div = st.tick_div + 16'h0001;
        end

        wk_timeout = 1'b0;
        if (st.wk_period == 3'h0) begin
            next_st.wk_count = 16'h0000; // R9
        end else if (WAKEUP_SRC_EXT ? EXT_CLK_TICK : tick) begin // R11
            if (st.wk_count >= period_last(st.wk_period, WAKEUP_SRC_EXT)) begin
                next_st.wk_count = 16'h0000;
                wk_timeout       = 1'b1;
            end else begin
                next_st.wk_count = st.wk_count + 16'h0001;
            end
        end

        if (wr_wk) begin
            next_st.wk_irq_en = WDATA[WK_IRQ_EN_BIT];
            if (WDATA[2:0] != st.wk_period) begin
                next_st.wk_count = 16'h0000;
            end
            next_st.wk_period = WDATA[2:0];
            if (WDATA[WK_ACK_BIT]) begin
                next_st.wk_flag = 1'b0; // R7
            end
        end
        // Set wins over a same-cycle acknowledge
        if (wk_timeout) begin
            next_st.wk_flag = 1'b1; // R6
        end

        if (wr_pm1) begin
            next_st.lv_irq_en = WDATA[PM_IRQ_EN_BIT];
            next_st.lv_stop_en = WDATA[PM_STOP_EN_BIT];
            next_st.bgap      = WDATA[PM_BGAP_BIT]; // R18
            if (!st.pm_once_written) begin // R2
                next_st.lv_rst_en       = WDATA[PM_RST_EN_BIT]; // R15
                next_st.lv_det_en       = WDATA[PM_DET_EN_BIT]; // R17
                next_st.pm_once_written = 1'b1;
            end
            if (WDATA[PM_ACK_BIT]) begin
                next_st.lv_flag = 1'b0; // R13
            end
        end
        if (WR && (ADDR == ADDR_PWR3)) begin
            next_st.trip_sel = WDATA[PM3_TRIP_BIT]; // R20
        end
        if (st.lv_sync && st.lv_det_en && (!STOP_MODE || st.lv_stop_en)) begin // R12 R16
            next_st.lv_flag = 1'b1; // R12
        end

        next_st.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                ADDR_OPT2:    next_st.rdata = {st.wdog_clk, 6'h00, st.cmp_route};
                ADDR_ID_HIGH: next_st.rdata = {4'h0, PART_ID[11:8]}; // R4 R5
                ADDR_ID_LOW:  next_st.rdata = PART_ID[7:0]; // R5
                ADDR_WAKEUP:  next_st.rdata = {st.wk_flag, 1'b0, 1'b0, st.wk_irq_en,
                                               1'b0, st.wk_period}; // R7
                ADDR_PWR1:    next_st.rdata = {st.lv_flag, 1'b0, st.lv_irq_en, st.lv_rst_en,
                                               st.lv_stop_en, st.lv_det_en, 1'b0, st.bgap}; // R13 R19
                ADDR_PWR3:    next_st.rdata = {2'h0, st.trip_sel, 5'h00};
                default:      next_st.rdata = 8'h00;
            endcase
        end

        next_st.capture  = st.cmp_route & COMPARATOR_OUT; // R3
        next_st.wake_irq = st.wk_flag & st.wk_irq_en; // R8
        next_st.lv_irq   = st.lv_flag & st.lv_irq_en; // R14
        next_st.lv_reset = st.lv_flag & st.lv_rst_en & st.lv_det_en; // R15 R17
        next_st.det_on   = st.lv_det_en & (!STOP_MODE | st.lv_stop_en); // R16 R17
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA                   = st.rdata;
    assign CAPTURE_CH0_IN          = st.capture;
    assign WATCHDOG_CLOCK_SELECT   = st.wdog_clk;
    assign WAKEUP_IRQ              = st.wake_irq;
    assign LOW_VOLTAGE_IRQ         = st.lv_irq;
    assign LOW_VOLTAGE_RESET       = st.lv_reset;
    assign DETECTOR_ENABLE         = st.det_on;
    assign LOW_VOLTAGE_TRIP_SELECT = st.trip_sel;
    assign BANDGAP_BUFFER_ENABLE   = st.bgap;

    property p_wdog_once;
        @(posedge CLK_SYS) disable iff (RST)
        st.opt_written |=> $stable(st.wdog_clk);
    endproperty
    a_wdog_once: assert property (p_wdog_once) else $error("watchdog select changed twice"); // R1

    property p_pm_once;
        @(posedge CLK_SYS) disable iff (RST)
        st.pm_once_written |=> ($stable(st.lv_det_en) && $stable(st.lv_rst_en));
    endproperty
    a_pm_once: assert property (p_pm_once) else $error("write-once bit changed"); // R2

    property p_route;
        @(posedge CLK_SYS) disable iff (RST)
        !st.cmp_route |=> !CAPTURE_CH0_IN;
    endproperty
    a_route: assert property (p_route) else $error("comparator leaked to capture"); // R3

    property p_id_read;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == ADDR_ID_LOW) |=> (RDATA == PART_ID[7:0]);
    endproperty
    a_id_read: assert property (p_id_read) else $error("part id low wrong"); // R5

    property p_wk_set;
        @(posedge CLK_SYS) disable iff (RST)
        wk_timeout |=> st.wk_flag;
    endproperty
    a_wk_set: assert property (p_wk_set) else $error("wakeup flag not set"); // R6

    property p_wk_ack;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_wk && WDATA[WK_ACK_BIT] && !wk_timeout) |=> !st.wk_flag;
    endproperty
    a_wk_ack: assert property (p_wk_ack) else $error("wakeup ack failed"); // R7

    property p_wk_irq;
        @(posedge CLK_SYS) disable iff (RST)
        (st.wk_flag && st.wk_irq_en) |=> WAKEUP_IRQ;
    endproperty
    a_wk_irq: assert property (p_wk_irq) else $error("wakeup irq missing"); // R8

    property p_lv_gate;
        @(posedge CLK_SYS) disable iff (RST)
        (!st.lv_det_en && !st.lv_flag) |=> !st.lv_flag;
    endproperty
    a_lv_gate: assert property (p_lv_gate) else $error("flag set while disabled"); // R12

    property p_lv_reset;
        @(posedge CLK_SYS) disable iff (RST)
        LOW_VOLTAGE_RESET |-> $past(st.lv_det_en);
    endproperty
    a_lv_reset: assert property (p_lv_reset) else $error("reset without detect enable"); // R17

    property p_wdog_first;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_opt && !st.opt_written) |=> WATCHDOG_CLOCK_SELECT == $past(WDATA[OPT_WDOG_CLK_BIT]);
    endproperty
    a_wdog_first: assert property (p_wdog_first) else $error("watchdog select not taken"); // R1

    property p_opt_refused;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_opt && st.opt_written) |=> $stable(st.cmp_route);
    endproperty
    a_opt_refused: assert property (p_opt_refused) else $error("option rewrite taken"); // R2

    property p_route_on;
        @(posedge CLK_SYS) disable iff (RST)
        (st.cmp_route && COMPARATOR_OUT) |=> CAPTURE_CH0_IN;
    endproperty
    a_route_on: assert property (p_route_on) else $error("comparator not routed"); // R3

    property p_id_high_top;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == ADDR_ID_HIGH) |=> (RDATA[7:4] == 4'h0);
    endproperty
    a_id_high_top: assert property (p_id_high_top) else $error("id high top bits wrong"); // R4

    property p_id_high_read;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == ADDR_ID_HIGH) |=> (RDATA[3:0] == PART_ID[11:8]);
    endproperty
    a_id_high_read: assert property (p_id_high_read) else $error("part id high wrong"); // R5

    property p_wk_sticky;
        @(posedge CLK_SYS) disable iff (RST)
        (st.wk_flag && !(wr_wk && WDATA[WK_ACK_BIT])) |=> st.wk_flag;
    endproperty
    a_wk_sticky: assert property (p_wk_sticky) else $error("wakeup flag lost"); // R6

    property p_wk_ack_read;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == ADDR_WAKEUP) |=> !RDATA[WK_ACK_BIT];
    endproperty
    a_wk_ack_read: assert property (p_wk_ack_read) else $error("wakeup ack read back"); // R7

    property p_wk_irq_off;
        @(posedge CLK_SYS) disable iff (RST)
        !st.wk_irq_en |=> !WAKEUP_IRQ;
    endproperty
    a_wk_irq_off: assert property (p_wk_irq_off) else $error("wakeup irq while disabled"); // R8

    property p_wk_off;
        @(posedge CLK_SYS) disable iff (RST)
        (st.wk_period == 3'h0) |-> !wk_timeout;
    endproperty
    a_wk_off: assert property (p_wk_off) else $error("timeout with timer off"); // R9

    property p_wk_ext_len;
        @(posedge CLK_SYS) disable iff (RST)
        (wk_timeout && WAKEUP_SRC_EXT && st.wk_period == 3'h1) |-> (st.wk_count == 16'd255);
    endproperty
    a_wk_ext_len: assert property (p_wk_ext_len) else $error("external period wrong"); // R10

    property p_tick_bound;
        @(posedge CLK_SYS) disable iff (RST)
        st.tick_div <= TICK_LAST;
    endproperty
    a_tick_bound: assert property (p_tick_bound) else $error("tick divider overran"); // R11

    property p_lv_sticky;
        @(posedge CLK_SYS) disable iff (RST)
        (st.lv_flag && !(wr_pm1 && WDATA[PM_ACK_BIT])) |=> st.lv_flag;
    endproperty
    a_lv_sticky: assert property (p_lv_sticky) else $error("low-voltage flag lost"); // R12

    property p_lv_ack;
        @(posedge CLK_SYS) disable iff (RST)
        (wr_pm1 && WDATA[PM_ACK_BIT] && !st.lv_sync) |=> !st.lv_flag;
    endproperty
    a_lv_ack: assert property (p_lv_ack) else $error("low-voltage ack failed"); // R13

    property p_lv_irq;
        @(posedge CLK_SYS) disable iff (RST)
        (st.lv_flag && st.lv_irq_en) |=> LOW_VOLTAGE_IRQ;
    endproperty
    a_lv_irq: assert property (p_lv_irq) else $error("low-voltage irq missing"); // R14

    property p_lv_irq_off;
        @(posedge CLK_SYS) disable iff (RST)
        !st.lv_irq_en |=> !LOW_VOLTAGE_IRQ;
    endproperty
    a_lv_irq_off: assert property (p_lv_irq_off) else $error("low-voltage irq while off"); // R14

    property p_lv_rst;
        @(posedge CLK_SYS) disable iff (RST)
        (st.lv_flag && st.lv_rst_en && st.lv_det_en) |=> LOW_VOLTAGE_RESET;
    endproperty
    a_lv_rst: assert property (p_lv_rst) else $error("low-voltage reset missing"); // R15

    property p_lv_stop;
        @(posedge CLK_SYS) disable iff (RST)
        (STOP_MODE && !st.lv_stop_en) |=> !DETECTOR_ENABLE;
    endproperty
    a_lv_stop: assert property (p_lv_stop) else $error("detector on in stop"); // R16

    property p_bgap;
        @(posedge CLK_SYS) disable iff (RST)
        wr_pm1 |=> (BANDGAP_BUFFER_ENABLE == $past(WDATA[PM_BGAP_BIT]));
    endproperty
    a_bgap: assert property (p_bgap) else $error("bandgap enable not taken"); // R18

    property p_trip;
        @(posedge CLK_SYS) disable iff (RST)
        (WR && ADDR == ADDR_PWR3) |=> (LOW_VOLTAGE_TRIP_SELECT == $past(WDATA[PM3_TRIP_BIT]));
    endproperty
    a_trip: assert property (p_trip) else $error("trip select not taken"); // R20
endmodule : sysopt_regs

// file: sim/sysopt_regs_tb_top.sv
// Self-checking testbench for the system options, wakeup timer and low-voltage register bank
`timescale 1ns/100ps
module sysopt_regs_tb_top
    import sysopt_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       rst     = 1'b1;
    logic [2:0] addr    = 3'h0;
    logic [7:0] wdata   = 8'h00;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] rdata;
    logic       lv      = 1'b0;
    logic       ext     = 1'b0;
    logic       cmp     = 1'b0;
    logic       src     = 1'b1;
    logic       stop    = 1'b0;
    logic       cap, wdog, wk_irq, lv_irq, lv_reset, det_en, trip, bgap;
    logic [7:0] d;
    int         bad_count   = 0;
    int         comparisons = 0;
    int         n;
    int         exp_t;
    // Rows: address, write data, value read back afterwards
    logic [18:0] rows [9] = '{
        {ADDR_OPT2, 8'h81, 8'h81}, {ADDR_OPT2, 8'h00, 8'h81},
        {ADDR_ID_HIGH, 8'hff, {4'h0, PART_ID[11:8]}}, {ADDR_ID_LOW, 8'h00, PART_ID[7:0]},
        {ADDR_PWR3, 8'h20, 8'h20}, {ADDR_PWR1, 8'h25, 8'h25}, {ADDR_PWR1, 8'h3d, 8'h2d},
        {ADDR_WAKEUP, 8'h57, 8'h17}, {3'h6, 8'hff, 8'h00}};
    logic [7:0] rst_exp [6] = '{8'h00, {4'h0, PART_ID[11:8]}, PART_ID[7:0], 8'h00, 8'h1c, 8'h00};

    always #10 clk_sys = ~clk_sys;

    sysopt_regs dut (
        .CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .LV_DETECT_ASYNC(lv), .EXT_CLK_TICK(ext), .WAKEUP_SRC_EXT(src),
        .STOP_MODE(stop), .COMPARATOR_OUT(cmp), .CAPTURE_CH0_IN(cap),
        .WATCHDOG_CLOCK_SELECT(wdog), .WAKEUP_IRQ(wk_irq), .LOW_VOLTAGE_IRQ(lv_irq),
        .LOW_VOLTAGE_RESET(lv_reset), .DETECTOR_ENABLE(det_en),
        .LOW_VOLTAGE_TRIP_SELECT(trip), .BANDGAP_BUFFER_ENABLE(bgap));

    task finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    task reg_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : reg_wr

    // Read data only stands in the cycle after the strobe
    task reg_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_rd

    task ticks(input int count);
        repeat (count) begin
            @(posedge clk_sys);
            ext <= 1'b1;
            @(posedge clk_sys);
            ext <= 1'b0;
        end
    endtask : ticks

    task wait_high(input int sel);
        int k;
        k = 0;
        while (((sel == 0) ? lv_irq : lv_reset) !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k >= 20) begin
            bad_count++;
            finish_test();
        end
    endtask : wait_high

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            reg_rd(3'(i), d);
            check(d, (i < 6) ? rst_exp[i] : 8'h00);
        end
        check({7'h0, det_en}, 8'h01);
        for (int i = 0; i < 9; i++) begin
            reg_wr(rows[i][18:16], rows[i][15:8]);
            reg_rd(rows[i][18:16], d);
            check(d, rows[i][7:0]);
        end
        check({4'h0, wdog, trip, bgap, det_en}, 8'h0f);
        @(posedge clk_sys);
        cmp <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({7'h0, cap}, 8'h01);
        cmp <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({7'h0, cap}, 8'h00);
        // Codes 1..3 with external ticks; codes 5 and up would blow the 5000-tick run budget
        for (int code = 1; code < 4; code++) begin
            reg_wr(ADDR_WAKEUP, 8'h10 | 8'(code));
            exp_t = (code == 1) ? 256 : (256 << code);
            n = 0;
            while (wk_irq !== 1'b1 && n < 5000) begin
                ticks(1);
                n++;
            end
            check(8'(n >= exp_t && n <= exp_t + 1), 8'h01);
            if (n >= 5000) begin
                finish_test();
            end
            reg_rd(ADDR_WAKEUP, d);
            check(d, 8'h90 | 8'(code));
            reg_wr(ADDR_WAKEUP, 8'h50 | 8'(code));
            reg_rd(ADDR_WAKEUP, d);
            check({d, wk_irq} , {8'h10 | 8'(code), 1'b0});
        end
        reg_wr(ADDR_WAKEUP, 8'h41);
        ticks(260);
        reg_rd(ADDR_WAKEUP, d);
        check({d, wk_irq}, {8'h81, 1'b0});
        // Internal source selected: external ticks must not count
        @(posedge clk_sys);
        src <= 1'b0;
        reg_wr(ADDR_WAKEUP, 8'h41);
        ticks(260);
        reg_rd(ADDR_WAKEUP, d);
        check(d, 8'h01);
        @(posedge clk_sys);
        src <= 1'b1;
        reg_wr(ADDR_WAKEUP, 8'h40);
        ticks(260);
        reg_rd(ADDR_WAKEUP, d);
        check(d, 8'h00);
        @(posedge clk_sys);
        lv <= 1'b1;
        wait_high(0);
        check({7'h0, lv_reset}, 8'h00);
        reg_rd(ADDR_PWR1, d);
        check(d, 8'had);
        @(posedge clk_sys);
        lv <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reg_wr(ADDR_PWR1, 8'h6d);
        reg_rd(ADDR_PWR1, d);
        check({d, lv_irq}, {8'h2d, 1'b0});
        // Stop mode with stop enable clear: detector idle, no flag
        reg_wr(ADDR_PWR1, 8'h25);
        stop <= 1'b1;
        lv   <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reg_rd(ADDR_PWR1, d);
        check({d, det_en, lv_irq}, {8'h25, 2'b00});
        @(posedge clk_sys);
        lv <= 1'b0;
        // Leave stop only once the synchroniser has drained
        repeat (4) @(posedge clk_sys);
        stop <= 1'b0;
        // Second reset in mid-run frees the write-once bits again
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        reg_wr(ADDR_OPT2, 8'h00);
        reg_wr(ADDR_OPT2, 8'h80);
        reg_rd(ADDR_OPT2, d);
        check({d, wdog, det_en}, {8'h00, 1'b0, 1'b1});
        @(posedge clk_sys);
        lv <= 1'b1;
        wait_high(1);
        check({7'h0, lv_reset}, 8'h01);
        // Third reset: detection written off, low voltage leaves no trace
        @(posedge clk_sys);
        lv  <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        reg_wr(ADDR_PWR1, 8'h00);
        lv <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reg_rd(ADDR_PWR1, d);
        check({d, det_en, lv_reset}, {8'h00, 2'b00});
        finish_test();
    end
endmodule : sysopt_regs_tb_top
